// >>> core/uart_status.v
// What this block does
// [RQ1] Overrun sets overrun_flag, status bit 5
// [RQ2] overrun_flag clears on 0 write after read-1
// [RQ3] Clearing rx_enable leaves error flags untouched
// [RQ4] Overrun keeps old byte, drops new data
// [RQ5] Overrun blocks reception; sync mode blocks transmission
// [RQ6] Framing error sets framing_error_flag, bit 4
// [RQ7] framing_error_flag clears on 0 after read-1
// [RQ8] Two stop bits: check only first
// [RQ9] Framing error: byte stored, rx_holding_full unset
// [RQ10] Framing flag blocks reception; sync blocks both
// [RQ11] Parity error sets parity_error_flag, bit 3
// [RQ12] parity_error_flag clears on 0 after read-1
// [RQ13] Parity error: byte stored, rx_holding_full unset
// [RQ14] Parity flag blocks reception; sync blocks both
// [RQ15] transmit_end_flag set: tx off or last bit
// [RQ16] transmit_end_flag cleared by empty-clear or data write
// [RQ17] Error flags: writing 1 never sets them
// [RQ18] Status bit 1 reserved, read-only
// [RQ19] Software writes 0 to status bit 0
// [RQ20] tx_holding_empty set: tx off or shift load
// [RQ21] rx_holding_full set on clean reception
// [RQ22] Overrun when reception completes while holding full
`include "uart_status_consts.vh"
`default_nettype none

module uart_status #(
    parameter [15:0] DIV_RESET = `DIVISOR_RESET
) (
    input  wire        core_clk,
    input  wire        rst,
    input  wire [4:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [3:0]  byteenable,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output reg         waitrequest,
    input  wire        rxd,
    output reg         txd,
    output reg         sclk
);

    // ------------------------------------------------------------
    // Bus slave: one wait state per access
    // ------------------------------------------------------------
    wire req = read | write;
    wire acc = req & ~waitrequest;
    wire wr_stat = acc & write & (address == `OFS_STATUS) & byteenable[0];
    wire rd_stat = acc & read & (address == `OFS_STATUS);
    wire wr_ctrl = acc & write & (address == `OFS_CONTROL) & byteenable[0];
    wire wr_txd  = acc & write & (address == `OFS_TXDATA) & byteenable[0];
    wire rd_rxd  = acc & read & (address == `OFS_RXDATA);
    wire wr_div  = acc & write & (address == `OFS_DIVISOR);

    reg  [5:0]  ctrl_q;
    reg  [15:0] div_q;
    reg  [7:0]  tdr_q;
    reg  [7:0]  rdr_q;
    reg         tx_holding_empty_q, rx_holding_full_q, ovr_q, frm_q, par_q, transmit_end_flag_q, rsv_q;
    reg  [7:3]  arm_q;

    wire te      = ctrl_q[`CT_TX_EN];
    wire re      = ctrl_q[`CT_RX_EN];
    wire sync_md = ctrl_q[`CT_SYNC];
    wire two_stp = ctrl_q[`CT_TWO_STOP];
    wire par_en  = ctrl_q[`CT_PAR_EN];
    wire par_odd = ctrl_q[`CT_PAR_ODD];
    wire err_any = ovr_q | frm_q | par_q;
    wire [15:0] half = {1'b0, div_q[15:1]};
    localparam [7:0] ST_RST = `STATUS_RESET;

    // Bit 1 always reads zero
    wire [7:0] status = {tx_holding_empty_q, rx_holding_full_q, ovr_q, frm_q, par_q, transmit_end_flag_q, 1'b0, rsv_q}; // [RQ18]

    reg [31:0] rd_mux;
    always @* begin
        case (address)
            `OFS_STATUS:  rd_mux = {24'h000000, status};
            `OFS_CONTROL: rd_mux = {26'h0000000, ctrl_q};
            `OFS_TXDATA:  rd_mux = {24'h000000, tdr_q};
            `OFS_RXDATA:  rd_mux = {24'h000000, rdr_q};
            `OFS_DIVISOR: rd_mux = {16'h0000, div_q};
            default:      rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h00000000;
        end else begin
            waitrequest <= ~(req & waitrequest);
            if (req & waitrequest) begin
                readdata <= read ? rd_mux : 32'h00000000;
            end
        end
    end

    // ------------------------------------------------------------
    // Control, divisor and transmit data registers
    // ------------------------------------------------------------
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `CONTROL_RESET;
            div_q  <= DIV_RESET;
            tdr_q  <= 8'h00;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= writedata[5:0];
            end
            if (wr_txd) begin
                tdr_q <= writedata[7:0];
            end
            // Very small divisors would collapse the half-bit sample point
            if (wr_div) begin
                if (byteenable[0]) begin
                    div_q[7:0] <= writedata[7:0];
                end
                if (byteenable[1]) begin
                    div_q[15:8] <= writedata[15:8];
                end
            end else if (div_q < `DIVISOR_MIN) begin
                div_q <= `DIVISOR_MIN;
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit engine, also clocks synchronous frames
    // ------------------------------------------------------------
    reg         tx_busy_q;
    reg  [15:0] tx_cnt_q;
    reg  [3:0]  tx_bits_q;
    reg  [11:0] tx_sh_q;
    reg         tx_load_q;

    wire tx_par   = par_odd ? ~(^tdr_q) : (^tdr_q);
    wire tx_have  = te & ~tx_holding_empty_q;
    // Errors stop a synchronous frame from starting in either direction
    wire sync_go  = ~err_any & (tx_have | (re & ~te)); // [RQ5] [RQ10] [RQ14]
    wire tx_go    = ~tx_busy_q & (sync_md ? sync_go : tx_have);
    wire bit_end  = tx_busy_q & (tx_cnt_q == div_q - 16'h0001);
    wire tx_last  = bit_end & (tx_bits_q == 4'h1);
    wire tx_load  = tx_go & tx_have;
    wire [3:0] async_len = 4'hA + {3'b000, par_en} + {3'b000, two_stp};

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_busy_q <= 1'b0;
            tx_cnt_q  <= 16'h0000;
            tx_bits_q <= 4'h0;
            tx_sh_q   <= 12'hFFF;
            tx_load_q <= 1'b0;
            txd       <= 1'b1;
            sclk      <= 1'b1;
        end else begin
            tx_load_q <= tx_load;
            if (~te & ~(sync_md & re)) begin
                tx_busy_q <= 1'b0;
                tx_sh_q   <= 12'hFFF;
            end else if (tx_go) begin
                tx_busy_q <= 1'b1;
                tx_cnt_q  <= 16'h0000;
                if (sync_md) begin
                    tx_bits_q <= 4'h8;
                    tx_sh_q   <= {4'hF, tx_have ? tdr_q : 8'hFF};
                end else begin
                    tx_bits_q <= async_len;
                    tx_sh_q   <= {2'b11, par_en ? tx_par : 1'b1, tdr_q, 1'b0};
                end
            end else if (tx_busy_q) begin
                if (bit_end) begin
                    tx_cnt_q  <= 16'h0000;
                    tx_bits_q <= tx_bits_q - 4'h1;
                    tx_sh_q   <= {1'b1, tx_sh_q[11:1]};
                    if (tx_last) begin
                        tx_busy_q <= 1'b0;
                    end
                end else begin
                    tx_cnt_q <= tx_cnt_q + 16'h0001;
                end
            end
            txd  <= tx_busy_q ? tx_sh_q[0] : 1'b1;
            sclk <= (tx_busy_q & sync_md) ? (tx_cnt_q >= half) : 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Receive engine
    // ------------------------------------------------------------
    localparam [1:0] RX_IDLE  = 2'b00;
    localparam [1:0] RX_START = 2'b01;
    localparam [1:0] RX_DATA  = 2'b10;

    reg         rxd_m_q, rxd_s_q;
    reg  [1:0]  rx_st_q;
    reg  [15:0] rx_cnt_q;
    reg  [3:0]  rx_bits_q;
    reg  [9:0]  rx_sh_q;
    reg  [7:0]  sy_sh_q;

    wire [9:0] rx_full = {rxd_s_q, rx_sh_q[9:1]};
    wire [7:0] a_data  = par_en ? rx_full[7:0] : rx_full[8:1];
    wire       a_pbit  = par_odd ? ~(^a_data) : (^a_data);
    wire       a_done  = (rx_st_q == RX_DATA) & (rx_cnt_q == div_q - 16'h0001)
                         & (rx_bits_q == 4'h1);
    // Only the first stop bit is sampled; a second one is never looked at
    wire       a_frm   = ~rx_full[9]; // [RQ8]
    wire       a_per   = par_en & (rx_full[8] != a_pbit);
    wire       s_samp  = tx_busy_q & sync_md & re & (tx_cnt_q == half);
    wire       s_done  = s_samp & (tx_bits_q == 4'h1);
    wire [7:0] s_data  = {rxd_s_q, sy_sh_q[7:1]};

    wire       rx_done = sync_md ? s_done : a_done;
    wire [7:0] rx_data = sync_md ? s_data : a_data;
    wire       rx_frm  = ~sync_md & a_frm;
    wire       rx_per  = ~sync_md & a_per;

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rxd_m_q   <= 1'b1;
            rxd_s_q   <= 1'b1;
            rx_st_q   <= RX_IDLE;
            rx_cnt_q  <= 16'h0000;
            rx_bits_q <= 4'h0;
            rx_sh_q   <= 10'h000;
            sy_sh_q   <= 8'h00;
        end else begin
            rxd_m_q <= rxd;
            rxd_s_q <= rxd_m_q;
            if (s_samp) begin
                sy_sh_q <= s_data;
            end
            case (rx_st_q)
                RX_IDLE: begin
                    // No new frame is accepted while any error flag stands
                    if (re & ~sync_md & ~err_any & ~rxd_s_q) begin // [RQ5] [RQ10] [RQ14]
                        rx_st_q  <= RX_START;
                        rx_cnt_q <= 16'h0000;
                    end
                end
                RX_START: begin
                    if (rx_cnt_q == half) begin
                        rx_cnt_q  <= 16'h0000;
                        rx_bits_q <= 4'h9 + {3'b000, par_en};
                        rx_st_q   <= rxd_s_q ? RX_IDLE : RX_DATA;
                    end else begin
                        rx_cnt_q <= rx_cnt_q + 16'h0001;
                    end
                end
                RX_DATA: begin
                    if (rx_cnt_q == div_q - 16'h0001) begin
                        rx_cnt_q  <= 16'h0000;
                        rx_sh_q   <= rx_full;
                        rx_bits_q <= rx_bits_q - 4'h1;
                        if (rx_bits_q == 4'h1) begin
                            rx_st_q <= RX_IDLE;
                        end
                    end else begin
                        rx_cnt_q <= rx_cnt_q + 16'h0001;
                    end
                end
                default: rx_st_q <= RX_IDLE;
            endcase
            if (~re | sync_md) begin
                rx_st_q <= RX_IDLE;
            end
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // A clear needs a prior read of the same bit as 1 since the last
    // status write; events in the clearing cycle still win.
    wire clr_tx_holding_empty = wr_stat & ~writedata[`ST_TX_HOLDING_EMPTY] & arm_q[`ST_TX_HOLDING_EMPTY];
    wire clr_rx_holding_full = wr_stat & ~writedata[`ST_RX_HOLDING_FULL] & arm_q[`ST_RX_HOLDING_FULL];
    wire clr_ovr  = wr_stat & ~writedata[`ST_OVR] & arm_q[`ST_OVR]; // [RQ2] [RQ17]
    wire clr_frm  = wr_stat & ~writedata[`ST_FRM] & arm_q[`ST_FRM]; // [RQ7] [RQ17]
    wire clr_par  = wr_stat & ~writedata[`ST_PAR] & arm_q[`ST_PAR]; // [RQ12] [RQ17]

    wire ev_ovr   = rx_done & rx_holding_full_q; // [RQ22] [RQ1]
    wire ev_frm   = rx_done & ~rx_holding_full_q & rx_frm; // [RQ6]
    wire ev_per   = rx_done & ~rx_holding_full_q & rx_per; // [RQ11]
    wire ev_rx_holding_full  = rx_done & ~rx_holding_full_q & ~rx_frm & ~rx_per; // [RQ21]
    wire ev_transmit_end_flag  = tx_last & tx_holding_empty_q; // [RQ15]

    wire tx_holding_empty_d = ~te | tx_load | (tx_holding_empty_q & ~clr_tx_holding_empty & ~wr_txd); // [RQ20]
    wire rx_holding_full_d = ev_rx_holding_full | (rx_holding_full_q & ~clr_rx_holding_full & ~rd_rxd);
    // rx_enable does not appear below: dropping it keeps the flags
    wire ovr_d  = ev_ovr | (ovr_q & ~clr_ovr); // [RQ3]
    wire frm_d  = ev_frm | (frm_q & ~clr_frm); // [RQ3]
    wire par_d  = ev_per | (par_q & ~clr_par); // [RQ3]
    wire transmit_end_flag_d = ~te | ev_transmit_end_flag | (transmit_end_flag_q & ~clr_tx_holding_empty & ~wr_txd); // [RQ15] [RQ16]
    wire [7:3] flags_d = {tx_holding_empty_d, rx_holding_full_d, ovr_d, frm_d, par_d};

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_holding_empty_q <= ST_RST[`ST_TX_HOLDING_EMPTY];
            rx_holding_full_q <= 1'b0;
            ovr_q  <= 1'b0;
            frm_q  <= 1'b0;
            par_q  <= 1'b0;
            transmit_end_flag_q <= 1'b1;
            rsv_q  <= 1'b0;
            arm_q  <= 5'h00;
            rdr_q  <= 8'h00;
        end else begin
            tx_holding_empty_q <= tx_holding_empty_d;
            rx_holding_full_q <= rx_holding_full_d;
            ovr_q  <= ovr_d;
            frm_q  <= frm_d;
            par_q  <= par_d;
            transmit_end_flag_q <= transmit_end_flag_d;
            // Stored as written; software keeps it at zero
            if (wr_stat) begin
                rsv_q <= writedata[`ST_RSV_WR]; // [RQ19]
            end
            arm_q <= flags_d & ~{5{wr_stat}} & (arm_q | ({5{rd_stat}} & readdata[7:3]));
            // Overrun leaves the held byte alone and the new one is lost
            if (rx_done & ~rx_holding_full_q) begin // [RQ4]
                rdr_q <= rx_data; // [RQ9] [RQ13]
            end
        end
    end

endmodule // uart_status

`default_nettype wire

// >>> core/uart_status_consts.vh
`ifndef UART_STATUS_CONSTS_VH
`define UART_STATUS_CONSTS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_STATUS      5'h00
`define OFS_CONTROL     5'h04
`define OFS_TXDATA      5'h08
`define OFS_RXDATA      5'h0C
`define OFS_DIVISOR     5'h10

// ------------------------------------------------------------
// Status register fields and reset value
// ------------------------------------------------------------
`define ST_TX_HOLDING_EMPTY         7
`define ST_RX_HOLDING_FULL         6
`define ST_OVR          5
`define ST_FRM          4
`define ST_PAR          3
`define ST_TRANSMIT_END_FLAG         2
`define ST_RSV_RD       1
`define ST_RSV_WR       0
`define STATUS_RESET    8'h84

// ------------------------------------------------------------
// Control register fields and reset value
// ------------------------------------------------------------
`define CT_TX_EN        0
`define CT_RX_EN        1
`define CT_SYNC         2
`define CT_TWO_STOP     3
`define CT_PAR_EN       4
`define CT_PAR_ODD      5
`define CONTROL_RESET   6'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define DIVISOR_RESET   16'h00D9
`define DIVISOR_MIN     16'h0004

`endif

// >>> tb/serial_peer.sv
`default_nettype none
module serial_peer #(
    parameter int DIV = 8
) (
    input  wire logic core_clk,
    input  wire logic txd,
    output var  logic rxd
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       par_en = 1'b0;
    logic       two_stop = 1'b0;
    logic       par_odd = 1'b0;
    logic [7:0] got_byte;
    logic       got_ok;
    event       got;
    // Line is pulled up, so idle reads high
    initial rxd = 1'b1;
    task automatic put(input logic v);
        rxd <= v;
        repeat (DIV) @(posedge core_clk);
    endtask
    task automatic send(input logic [7:0] b, input logic bp, input logic bs, input logic s2);
        put(1'b0);
        for (int i = 0; i < 8; i++) put(b[i]);
        if (par_en) put(^b ^ bp ^ par_odd);
        put(!bs);
        if (two_stop) put(s2);
        rxd <= 1'b1;
    endtask
    // Mid-bit sampling leaves ample margin for the one-cycle txd lag
    initial forever begin
        @(negedge txd);
        repeat (DIV / 2) @(posedge core_clk);
        got_ok = !txd;
        for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge core_clk);
            got_byte[i] = txd;
        end
        if (par_en) begin
            repeat (DIV) @(posedge core_clk);
            got_ok &= (txd == ^got_byte);
        end
        repeat (DIV) @(posedge core_clk);
        got_ok &= txd;
        -> got;
    end
endmodule // serial_peer
`default_nettype wire

// >>> tb/tb.sv
`include "uart_status_consts.vh"
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin n_errors++; \
    $display("wrong value %s exp %h got %h", nm, e, s); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DIV = 8;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [4:0]  address = 5'h00;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest, rxd, txd, sclk;
    logic [31:0] seed = 32'h6BAD;
    logic [7:0]  b, k;
    logic [63:0] e;
    logic [7:0]  tq[$];
    logic [63:0] bq[$];
    int          n_errors = 0;
    int          n_tests = 0;
    always #20 core_clk = ~core_clk;
    uart_status #(.DIV_RESET(16'h0008)) DUT (.core_clk(core_clk), .rst(rst), .address(address),
        .read(read), .write(write), .byteenable(4'hF), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .rxd(rxd), .txd(txd), .sclk(sclk));
    serial_peer #(.DIV(DIV)) peer (.core_clk(core_clk), .txd(txd), .rxd(rxd));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Extra edge at the end keeps back-to-back calls from double-driving the strobes
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d});
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] m, input logic [7:0] x);
        bq.push_back({24'hFFFFFF, m, 24'h0, x & m});
        bus(1'b0, a, 32'h0);
    endtask
    task automatic rx(input logic bp, input logic bs, input logic s2);
        seed = lfsr(seed);
        b = seed[7:0];
        peer.send(b, bp, bs, s2);
        repeat (4) @(posedge core_clk);
    endtask
    always @(posedge core_clk) begin
        if (read && waitrequest === 1'b0) begin
            e = bq.pop_front();
            `CHK("readdata", e[31:0], readdata & e[63:32])
        end
    end
    always @(peer.got) begin
        `CHK("serial byte", {1'b1, tq.pop_front()}, {peer.got_ok, peer.got_byte})
    end
    task automatic final_report;
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge core_clk);
        n_errors++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd(`OFS_STATUS, 8'hFF, 8'h84);
        rd(`OFS_CONTROL, 8'hFF, 8'h00);
        rd(5'h14, 8'hFF, 8'h00);
        wr(`OFS_STATUS, 8'hFE);
        rd(`OFS_STATUS, 8'hFF, 8'h84);
        wr(`OFS_CONTROL, 8'h13);
        peer.par_en = 1'b1;
        repeat (3) begin
            seed = lfsr(seed);
            tq.push_back(seed[7:0]);
            wr(`OFS_TXDATA, seed[7:0]);
            rd(`OFS_STATUS, 8'h04, 8'h00);
            @(peer.got);
            repeat (DIV) @(posedge core_clk);
            rd(`OFS_STATUS, 8'h84, 8'h84);
        end
        rx(1'b0, 1'b0, 1'b1);
        k = b;
        rd(`OFS_STATUS, 8'h78, 8'h40);
        rx(1'b0, 1'b0, 1'b1);
        wr(`OFS_STATUS, 8'hC4);
        rd(`OFS_STATUS, 8'h78, 8'h60);
        rd(`OFS_RXDATA, 8'hFF, k);
        rx(1'b0, 1'b0, 1'b1);
        rd(`OFS_STATUS, 8'h78, 8'h20);
        rd(`OFS_RXDATA, 8'hFF, k);
        wr(`OFS_CONTROL, 8'h11);
        rd(`OFS_STATUS, 8'h38, 8'h20);
        wr(`OFS_STATUS, 8'hC4);
        rd(`OFS_STATUS, 8'hFF, 8'h84);
        wr(`OFS_CONTROL, 8'h13);
        for (int i = 0; i < 2; i++) begin
            rx(i[0], !i[0], 1'b1);
            k = b;
            rd(`OFS_STATUS, 8'h78, i ? 8'h08 : 8'h10);
            rd(`OFS_RXDATA, 8'hFF, k);
            rx(1'b0, 1'b0, 1'b1);
            rd(`OFS_STATUS, 8'h78, i ? 8'h08 : 8'h10);
            rd(`OFS_RXDATA, 8'hFF, k);
            wr(`OFS_STATUS, 8'hC4);
            rd(`OFS_STATUS, 8'hFF, 8'h84);
        end
        wr(`OFS_CONTROL, 8'h33);
        peer.par_odd = 1'b1;
        rx(1'b0, 1'b0, 1'b1);
        rd(`OFS_STATUS, 8'h78, 8'h40);
        rd(`OFS_RXDATA, 8'hFF, b);
        peer.par_odd = 1'b0;
        wr(`OFS_CONTROL, 8'h1B);
        peer.two_stop = 1'b1;
        rx(1'b0, 1'b0, 1'b0);
        rd(`OFS_STATUS, 8'h58, 8'h40);
        rd(`OFS_RXDATA, 8'hFF, b);
        wr(`OFS_CONTROL, 8'h00);
        rd(`OFS_STATUS, 8'h84, 8'h84);
        final_report();
    end
endmodule // tb
`default_nettype wire

// >>> tb/uart_status_checker.sv
`include "uart_status_consts.vh"
`default_nettype none
module uart_status_checker (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [4:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        rxd,
    input wire logic        txd,
    input wire logic        sclk
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       acc;
    logic       st_rd;
    logic       st_wr;
    logic       te_q;
    logic [2:0] seen_q;
    logic [2:0] clr_q;
    assign acc = (read | write) & ~waitrequest;
    assign st_rd = acc & read & (address == `OFS_STATUS);
    assign st_wr = acc & write & (address == `OFS_STATUS) & byteenable[0];
    // Error flags seen at the last status read may only vanish after a zero was written
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            te_q <= 1'b0;
            seen_q <= 3'h0;
            clr_q <= 3'h0;
        end else begin
            if (acc & write & (address == `OFS_CONTROL) & byteenable[0]) begin
                te_q <= writedata[`CT_TX_EN];
            end
            if (st_rd) begin
                seen_q <= readdata[`ST_OVR:`ST_PAR];
                clr_q <= 3'h0;
            end else if (st_wr) begin
                clr_q <= clr_q | ~writedata[`ST_OVR:`ST_PAR];
            end
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_req; (read | write) && waitrequest; endsequence
    sequence s_ans; !waitrequest ##1 waitrequest; endsequence
    AST_ONE_WAIT: assert property (s_req |=> s_ans)
        else $error("not one wait state");
    AST_WAIT_CAUSE: assert property (!waitrequest |-> $past(read | write))
        else $error("answer without request");
    AST_UNMAPPED: assert property (acc && read && !(address inside {`OFS_STATUS,
        `OFS_CONTROL, `OFS_TXDATA, `OFS_RXDATA, `OFS_DIVISOR}) |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_WRITE_ZERO: assert property (acc && write |-> readdata == 32'h0)
        else $error("readdata not zero on write");
    AST_RSV_BIT: assert property (st_rd |-> !readdata[`ST_RSV_RD])
        else $error("reserved bit set");
    AST_TX_OFF: assert property (st_rd && !te_q |-> readdata[7] && readdata[2])
        else $error("tx flags low with tx off");
    AST_FLAG_KEEP: assert property (st_rd |-> (seen_q & ~readdata[5:3] & ~clr_q) == 3'h0)
        else $error("error flag lost without clear");
    AST_TXD_IDLE: assert property (!te_q [*3] |-> txd)
        else $error("txd active with tx off");
endmodule // uart_status_checker
bind uart_status uart_status_checker u_chk (.core_clk(core_clk), .rst(rst), .address(address),
    .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .rxd(rxd), .txd(txd), .sclk(sclk));
`default_nettype wire
